/* File: design/adc_timing_sequencer.sv */
`timescale 1ns/1ps
module adc_timing_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic          sys_clk_in,
    input  wire logic          resetn_in,
    input  wire logic [2:0]    addr_in,
    input  wire logic [7:0]    wr_data_in,
    input  wire logic          wr_in,
    input  wire logic          rd_in,
    input  wire logic          trigger_in,
    input  wire logic          supply_ready_in,
    input  wire logic [9:0]    result_in,
    output logic [7:0]         rd_data_out,
    output logic               supply_enable_out,
    output logic               conv_tick_out,
    output logic               sample_hold_out,
    output logic               converting_out,
    output logic               tracking_out,
    output logic               settling_out,
    output selection_type      selection_out,
    output logic [9:0]         data_out
);

    // ********************************************************
    // Phase lengths in converter clock ticks
    // ********************************************************
    function automatic logic [8:0] startup_len(input timing_type t);
        return {1'b0, t.startup_time_field, 2'b00} + 9'h004;
    endfunction : startup_len

    function automatic logic [8:0] amp_len(input timing_type t);
        return {6'h00, t.track_hold_time_field, 1'b0} + 9'h006;
    endfunction : amp_len

    function automatic logic [8:0] track_len(input timing_type t,
                                             input logic diff);
        if (diff) begin
            return {6'h00, t.track_hold_time_field, 1'b0} + 9'h003;
        end
        return {7'h00, t.track_hold_time_field} + 9'h001;
    endfunction : track_len

    function automatic logic [8:0] settle_len(input timing_type t,
                                              input logic diff);
        if (diff) begin
            return startup_len(t)
                + {6'h00, t.track_hold_time_field, 1'b0} + 9'h004;
        end
        return {7'h00, t.track_hold_time_field} + 9'h002;
    endfunction : settle_len

    // ********************************************************
    // State
    // ********************************************************
    seq_state_type state;
    seq_state_type next_state;
    logic [8:0]    phase_cnt;
    logic [8:0]    next_cnt;
    logic [7:0]    div_cnt;
    logic          enable;
    logic          start;
    logic          auto_trig;
    logic          done;
    logic [2:0]    div_sel;
    logic          free_sel;
    logic          chan_hi;
    timing_type    timing_buf;
    timing_type    timing_act;
    selection_type sel_buf;
    selection_type sel_act;
    logic          sel_lock;
    logic          settle_pend;
    logic          trig_prev;
    logic [TRIG_SYNC_CYCLES-1:0] trig_pipe;
    logic [9:0]    result;
    logic [8:0]    ph_ticks;

    // ********************************************************
    // Decoding
    // ********************************************************
    wire wr_a = wr_in && (addr_in == ADDR_CTRL_A);
    wire wr_b = wr_in && (addr_in == ADDR_CTRL_B);
    wire wr_t = wr_in && (addr_in == ADDR_TIMING);
    wire wr_c = wr_in && (addr_in == ADDR_CHAN);
    wire [7:0] div_mask = ~(8'hfe << div_sel);
    wire tick = enable && ((div_cnt & div_mask) == div_mask);
    wire diff = sel_act.channel_select_bits[5];
    wire free_run = auto_trig && free_sel;
    wire phase_done = tick && (phase_cnt == 9'h000);
    // Edges are only accepted while idle, so a busy converter drops them.
    wire trig_edge = auto_trig && !free_sel && trigger_in && !trig_prev
                     && (state == ST_IDLE) && (trig_pipe == '0);
    wire trig_req = trig_pipe[TRIG_SYNC_CYCLES-1];
    wire start_req = start || trig_req;
    wire conv_end = (state == ST_CONVERT) && phase_done;
    wire supply_ok = (state != ST_OFF) && (state != ST_SUPPLY);
    wire operating = (state == ST_IDLE) || (state == ST_TRACK)
                     || (state == ST_SETTLE);
    wire timing_safe = (state == ST_OFF) || (state == ST_SUPPLY)
                       || (state == ST_IDLE);
    wire sel_change = enable && operating && !sel_lock
                      && (sel_buf != sel_act);
    // Free running restarts skip the delay state, so lock on that path too.
    wire lock_now = ((state != ST_DELAY) && (next_state == ST_DELAY))
                    || ((state == ST_TRACK) && (next_state == ST_CONVERT));
    wire [7:0] ctrl_a = {enable, start, auto_trig, done, 1'b0, div_sel};
    wire [7:0] ctrl_b = {supply_ok, 3'h0, chan_hi, 2'h0, free_sel};
    wire [7:0] rd_mux =
        (addr_in == ADDR_CTRL_A) ? ctrl_a :
        (addr_in == ADDR_CTRL_B) ? ctrl_b :
        (addr_in == ADDR_TIMING) ? timing_buf :
        (addr_in == ADDR_CHAN)   ? {sel_buf.reference_select, 1'b0,
                                    sel_buf.channel_select_bits[4:0]} :
        (addr_in == ADDR_RES_LO) ? result[7:0] :
        (addr_in == ADDR_RES_HI) ? {6'h00, result[9:8]} : 8'h00;

    assign supply_enable_out = enable;
    assign conv_tick_out     = tick;
    assign sample_hold_out   = (state == ST_DELAY)
                               && (next_state == ST_CONVERT);
    assign converting_out    = (state == ST_CONVERT);
    assign tracking_out      = (state == ST_TRACK);
    assign settling_out      = (state == ST_SETTLE);
    assign selection_out     = sel_act;
    assign data_out          = result;

    // ********************************************************
    // Sequencer
    // ********************************************************
    always_comb begin
        next_state = state;
        next_cnt   = phase_cnt;
        if (tick && (phase_cnt != 9'h000)) begin
            next_cnt = phase_cnt - 9'h001;
        end
        case (state)
            ST_OFF: begin
                if (enable) begin
                    next_state = ST_SUPPLY;
                end
            end
            ST_SUPPLY: begin
                if (supply_ready_in) begin
                    next_state = ST_STARTUP;
                    next_cnt   = startup_len(timing_act) - 9'h001;
                end
            end
            ST_STARTUP: begin
                if (phase_done && diff) begin
                    next_state = ST_AMP;
                    next_cnt   = amp_len(timing_act) - 9'h001;
                end else if (phase_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_AMP, ST_SETTLE: begin
                if (phase_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (settle_pend) begin
                    next_state = ST_SETTLE;
                    next_cnt   = settle_len(timing_act, diff) - 9'h001;
                end else if (start_req) begin
                    next_state = ST_DELAY;
                    next_cnt   = diff ? DIFF_DELAY_TICKS - 9'h001
                                      : SE_DELAY_CPU - 9'h001;
                end
            end
            ST_DELAY: begin
                // Single-ended delay counts CPU cycles, not ticks.
                if (!diff && (phase_cnt == 9'h000)) begin
                    next_state = ST_CONVERT;
                    next_cnt   = CONV_TICKS - 9'h001;
                end else if (!diff) begin
                    next_cnt = phase_cnt - 9'h001;
                end else if (phase_done) begin
                    next_state = ST_CONVERT;
                    next_cnt   = CONV_TICKS - 9'h001;
                end
            end
            ST_CONVERT: begin
                if (phase_done) begin
                    next_state = ST_TRACK;
                    next_cnt   = track_len(timing_act, diff) - 9'h001;
                end
            end
            ST_TRACK: begin
                if (settle_pend) begin
                    next_state = ST_SETTLE;
                    next_cnt   = settle_len(timing_act, diff) - 9'h001;
                end else if (phase_done && free_run && start) begin
                    next_state = ST_CONVERT;
                    next_cnt   = CONV_TICKS - 9'h001;
                end else if (phase_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (!enable) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state     <= ST_OFF;
            phase_cnt <= 9'h000;
        end else begin
            state     <= next_state;
            phase_cnt <= next_cnt;
        end
    end

    // ********************************************************
    // Divider and trigger synchroniser
    // ********************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || !enable || trig_edge) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            trig_prev <= 1'b0;
            trig_pipe <= '0;
        end else begin
            trig_prev <= trigger_in;
            trig_pipe <= {trig_pipe[TRIG_SYNC_CYCLES-2:0], trig_edge};
        end
    end

    // ********************************************************
    // Software registers
    // ********************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            enable    <= 1'b0;
            auto_trig <= 1'b0;
            div_sel   <= 3'h0;
            free_sel  <= 1'b0;
            chan_hi   <= 1'b0;
            timing_buf <= TIMING_RESET;
            sel_buf   <= CHAN_RESET;
        end else begin
            if (wr_a) begin
                enable    <= wr_data_in[CA_ENABLE];
                auto_trig <= wr_data_in[CA_AUTO];
                div_sel   <= wr_data_in[2:0];
            end
            if (wr_b) begin
                chan_hi  <= wr_data_in[CB_CHAN_HI];
                free_sel <= wr_data_in[CB_FREE_RUN];
            end
            if (wr_t) begin
                timing_buf <= wr_data_in;
            end
            if (wr_c) begin
                sel_buf <= {wr_data_in[7:6], chan_hi,
                            wr_data_in[4:0]};
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            start <= 1'b0;
            done  <= 1'b0;
        end else begin
            if ((wr_a && wr_data_in[CA_START]) || trig_req) begin
                start <= 1'b1;
            end else if (!enable || (conv_end && !free_run)) begin
                start <= 1'b0;
            end
            if (conv_end) begin
                done <= 1'b1;
            end else if (wr_a && wr_data_in[CA_DONE]) begin
                done <= 1'b0;
            end
        end
    end

    // ********************************************************
    // Active selection, timing and result
    // ********************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sel_act     <= CHAN_RESET;
            sel_lock    <= 1'b0;
            settle_pend <= 1'b0;
            timing_act  <= TIMING_RESET;
            result      <= 10'h000;
            rd_data_out <= 8'h00;
        end else begin
            if (!sel_lock && !lock_now) begin
                sel_act <= sel_buf;
            end
            if (lock_now) begin
                sel_lock <= 1'b1;
            end else if (conv_end || !enable) begin
                sel_lock <= 1'b0;
            end
            if (sel_change) begin
                settle_pend <= 1'b1;
            end else if (((state != ST_SETTLE) && (next_state == ST_SETTLE))
                         || !enable) begin
                // A change made while settling stays pending for a rerun.
                settle_pend <= 1'b0;
            end
            if (timing_safe) begin
                timing_act <= timing_buf;
            end
            if (conv_end) begin
                result <= result_in;
            end
            rd_data_out <= rd_in ? rd_mux : 8'h00;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || (state != next_state)) begin
            ph_ticks <= 9'h000;
        end else if (tick) begin
            ph_ticks <= ph_ticks + 9'h001;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_divider_held: assert property (
        !enable |=> (div_cnt == 8'h00))
        else $error("divider not held while disabled");
    a_supply_first: assert property (
        (state == ST_STARTUP && $past(state) == ST_SUPPLY)
        |-> $past(supply_ready_in))
        else $error("start-up began before supply stable");
    a_startup_len: assert property (
        ($past(state) == ST_STARTUP && state != ST_STARTUP
         && state != ST_OFF)
        |-> ($past(ph_ticks) == startup_len(timing_act) - 9'h001))
        else $error("start-up length wrong");
    a_amp_init_len: assert property (
        ($past(state) == ST_AMP && state == ST_IDLE)
        |-> ($past(ph_ticks) == amp_len(timing_act) - 9'h001))
        else $error("amplifier init length wrong");
    a_conv_len: assert property (
        ($past(state) == ST_CONVERT && state == ST_TRACK)
        |-> ($past(ph_ticks) == CONV_TICKS - 9'h001))
        else $error("conversion length wrong");
    a_done_result: assert property (
        conv_end |=> (done && result == $past(result_in)))
        else $error("completion did not store result");
    a_se_delay: assert property (
        (state == ST_IDLE && next_state == ST_DELAY && !diff && enable)
        |-> ##2 sample_hold_out)
        else $error("single-ended start delay wrong");
    a_trig_sync: assert property (
        trig_edge |-> ##3 trig_req)
        else $error("trigger synchronisation delay wrong");
    a_track_gate: assert property (
        (state == ST_TRACK) |=> (state != ST_DELAY))
        else $error("conversion requested inside tracking");
    a_free_run: assert property (
        (state == ST_TRACK && !settle_pend && phase_done && free_run
         && start && enable) |=> (state == ST_CONVERT))
        else $error("free running did not restart");
    a_sel_locked: assert property (
        (state == ST_CONVERT) ##1 (state == ST_CONVERT)
        |-> $stable(sel_act))
        else $error("selection changed during conversion");
    a_cfg_stable: assert property (
        (state == ST_CONVERT)
        |=> (state != ST_CONVERT || $stable(timing_act)))
        else $error("timing settings changed during conversion");

endmodule : adc_timing_sequencer

/* File: design/adc_seq_pkg.sv */
package adc_seq_pkg;

    // ********************************************************
    // Register map and field positions
    // ********************************************************
    localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
    localparam logic [2:0] ADDR_TIMING  = 3'h2;
    localparam logic [2:0] ADDR_CHAN    = 3'h3;
    localparam logic [2:0] ADDR_RES_LO  = 3'h4;
    localparam logic [2:0] ADDR_RES_HI  = 3'h5;

    localparam int CA_ENABLE   = 7;
    localparam int CA_START    = 6;
    localparam int CA_AUTO     = 5;
    localparam int CA_DONE     = 4;
    localparam int CB_SUPPLY   = 7;
    localparam int CB_CHAN_HI  = 3;
    localparam int CB_FREE_RUN = 0;

    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] CHAN_RESET   = 8'h00;

    // ********************************************************
    // Timing counts
    // ********************************************************
    localparam logic [8:0] SE_DELAY_CPU     = 9'h002;
    localparam logic [8:0] DIFF_DELAY_TICKS = 9'h002;
    localparam int         TRIG_SYNC_CYCLES = 3;
    localparam logic [8:0] CONV_TICKS       = 9'h00b;

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic [1:0] track_hold_time_field;
        logic [5:0] startup_time_field;
    } timing_type;

    typedef struct packed {
        logic [1:0] reference_select;
        logic [5:0] channel_select_bits;
    } selection_type;

    typedef enum logic [3:0] {
        ST_OFF     = 4'h0,
        ST_SUPPLY  = 4'h1,
        ST_STARTUP = 4'h2,
        ST_AMP     = 4'h3,
        ST_IDLE    = 4'h4,
        ST_SETTLE  = 4'h5,
        ST_DELAY   = 4'h6,
        ST_CONVERT = 4'h7,
        ST_TRACK   = 4'h8
    } seq_state_type;

endpackage : adc_seq_pkg

/* File: dv/adc_timing_sequencer_tb.sv */
`timescale 1ns/1ps
module adc_timing_sequencer_tb;
    import adc_seq_pkg::*;

    // ********************************************************
    // Signals
    // ********************************************************
    logic          sys_clk_in;
    logic          resetn_in;
    logic [2:0]    addr_in;
    logic [7:0]    wr_data_in;
    logic          wr_in;
    logic          rd_in;
    logic          trigger_in;
    logic          supply_ready_in;
    logic [9:0]    result_in;
    logic [7:0]    rd_data_out;
    logic          supply_enable_out;
    logic          conv_tick_out;
    logic          sample_hold_out;
    logic          converting_out;
    logic          tracking_out;
    logic          settling_out;
    selection_type selection_out;
    logic [9:0]    data_out;
    int            mismatches;
    int            checks_done;
    int            cyc;
    int            seed;
    int            n;
    logic          rd_prev;
    logic [7:0]    expq[$];

    adc_timing_sequencer uut (
        .sys_clk_in        (sys_clk_in),
        .resetn_in         (resetn_in),
        .addr_in           (addr_in),
        .wr_data_in        (wr_data_in),
        .wr_in             (wr_in),
        .rd_in             (rd_in),
        .trigger_in        (trigger_in),
        .supply_ready_in   (supply_ready_in),
        .result_in         (result_in),
        .rd_data_out       (rd_data_out),
        .supply_enable_out (supply_enable_out),
        .conv_tick_out     (conv_tick_out),
        .sample_hold_out   (sample_hold_out),
        .converting_out    (converting_out),
        .tracking_out      (tracking_out),
        .settling_out      (settling_out),
        .selection_out     (selection_out),
        .data_out          (data_out)
    );

    always #10 sys_clk_in = ~sys_clk_in;

    // ********************************************************
    // Checking and closing
    // ********************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Read data stands only in the cycle after the strobe, so the
    // watcher compares in exactly that cycle.
    always @(posedge sys_clk_in) rd_prev <= rd_in;
    always @(negedge sys_clk_in) begin
        if (rd_prev === 1'b1 && expq.size() > 0)
            check(rd_data_out, expq.pop_front());
    end

    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ********************************************************
    // Bus and phase tasks
    // ********************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= 1'b1;
        @(posedge sys_clk_in);
        wr_in      <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        expq.push_back(exp);
        @(posedge sys_clk_in);
        rd_in   <= 1'b0;
    endtask : rd

    function automatic logic sig(input int k);
        case (k)
            0: return converting_out;
            1: return tracking_out;
            default: return settling_out;
        endcase
    endfunction : sig

    task automatic wait_rise(input int k);
        int i;
        for (i = 0; i < 3000 && sig(k) !== 1'b1; i++) @(negedge sys_clk_in);
    endtask : wait_rise

    // Counts converter ticks seen while the chosen phase stands.
    task automatic phase_ticks(input int k, output int cnt);
        cnt = 0;
        wait_rise(k);
        while (sig(k) === 1'b1) begin
            if (conv_tick_out === 1'b1) cnt++;
            @(negedge sys_clk_in);
        end
    endtask : phase_ticks

    task automatic idle(input int c);
        repeat (c) @(negedge sys_clk_in);
    endtask : idle

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        sys_clk_in = 0; resetn_in = 0; addr_in = 3'h0; wr_data_in = 8'h00;
        wr_in = 0; rd_in = 0; trigger_in = 0; supply_ready_in = 0;
        result_in = 10'h000; mismatches = 0; checks_done = 0; cyc = 0;
        seed = 93951;
        repeat (12) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
        wr(ADDR_TIMING, 8'h40);
        rd(ADDR_TIMING, 8'h40);
        wr(ADDR_CTRL_A, 8'h02);
        n = 0;
        repeat (40) begin
            @(negedge sys_clk_in);
            if (conv_tick_out !== 1'b0) n++;
        end
        check(n, 0);
        wr(ADDR_CTRL_A, 8'h82);
        idle(2);
        check(supply_enable_out, 1);
        rd(ADDR_CTRL_B, 8'h00);
        @(posedge sys_clk_in) supply_ready_in <= 1'b1;
        idle(3);
        rd(ADDR_CTRL_B, 8'h80);
        // Divide by 2^(2+1): ticks come every 8 cycles.
        do @(negedge sys_clk_in);
        while (conv_tick_out !== 1'b1);
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (conv_tick_out !== 1'b1 && n < 100);
        check(n, 8);
        idle(80);
        // Single-ended single conversion with a channel write in flight.
        @(posedge sys_clk_in) result_in <= 10'($random(seed));
        wr(ADDR_CTRL_A, 8'hc2);
        idle(2);
        check(sample_hold_out, 0);
        idle(1);
        check(sample_hold_out, 1);
        // Phases are counted from their first cycle, beside the bus work.
        fork
            phase_ticks(0, n);
            begin
                rd(ADDR_CTRL_A, 8'hc2);
                wr(ADDR_CHAN, 8'h05);
                idle(2);
                check(selection_out, 8'h00);
            end
        join
        check(n, 11);
        fork
            phase_ticks(2, n);
            begin
                idle(2);
                check(data_out, result_in);
                check(selection_out, 8'h05);
                rd(ADDR_CTRL_A, 8'h92);
                rd(ADDR_RES_LO, result_in[7:0]);
                rd(ADDR_RES_HI, {6'h00, result_in[9:8]});
            end
        join
        check(n, 3);
        wr(ADDR_CTRL_A, 8'h92);
        rd(ADDR_CTRL_A, 8'h82);
        rd(ADDR_CHAN, 8'h05);
        // Second single start after the done clear: tracking must run its full length.
        wr(ADDR_CTRL_A, 8'hc2);
        wait_rise(0);
        phase_ticks(1, n);
        check(n, 2);
        idle(40);
        // Auto trigger: sync adds three cycles before the start delay.
        wr(ADDR_CTRL_A, 8'ha2);
        @(posedge sys_clk_in) trigger_in <= 1'b1;
        idle(5);
        check(sample_hold_out, 0);
        idle(1);
        check(sample_hold_out, 1);
        wait_rise(0);
        @(posedge sys_clk_in) trigger_in <= 1'b0;
        idle(4);
        @(posedge sys_clk_in) trigger_in <= 1'b1;
        while (converting_out === 1'b1) @(negedge sys_clk_in);
        n = 0;
        repeat (120) begin
            @(negedge sys_clk_in);
            if (converting_out !== 1'b0) n++;
        end
        check(n, 0);
        @(posedge sys_clk_in) trigger_in <= 1'b0;
        // Free running: period is tracking plus eleven ticks.
        wr(ADDR_CTRL_B, 8'h01);
        wr(ADDR_CTRL_A, 8'he2);
        wait_rise(0);
        n = 0;
        while (converting_out === 1'b1) begin
            if (conv_tick_out === 1'b1) n++;
            @(negedge sys_clk_in);
        end
        for (int i = 0; i < 400 && converting_out !== 1'b1; i++) begin
            if (conv_tick_out === 1'b1) n++;
            @(negedge sys_clk_in);
        end
        check(n, 13);
        wr(ADDR_CTRL_A, 8'h82);
        idle(300);
        wr(ADDR_CTRL_B, 8'h00);
        idle(20);
        // High channel bit alone must not reach the active selection.
        wr(ADDR_CTRL_B, 8'h08);
        idle(4);
        check(selection_out, 8'h05);
        rd(ADDR_CTRL_B, 8'h88);
        wr(ADDR_CHAN, 8'h05);
        idle(4);
        check(selection_out, 8'h25);
        wr(ADDR_CTRL_A, 8'h00);
        idle(3);
        check(supply_enable_out, 0);
        n = 0;
        repeat (40) begin
            @(negedge sys_clk_in);
            if (conv_tick_out !== 1'b0) n++;
        end
        check(n, 0);
        // Differential channel: amplifier init, tick-based start delay and
        // the longer tracking phase; the divider drops to 1/32 first.
        wr(ADDR_CTRL_A, 8'h04);
        @(posedge sys_clk_in) result_in <= 10'($random(seed));
        wr(ADDR_CTRL_A, 8'hc4);
        phase_ticks(0, n);
        check(n, 11);
        phase_ticks(1, n);
        check(n, 5);
        check(data_out, result_in);
        wr(ADDR_CTRL_A, 8'h00);
        idle(4);
        conclude();
    end

endmodule : adc_timing_sequencer_tb
